// >>> include/word_alloc_defs.svh
// Register offsets, field positions, slave kinds and start-up timing.
`ifndef WORD_ALLOC_DEFS_SVH
`define WORD_ALLOC_DEFS_SVH

`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define IN_W0_OFS 12'h010
`define OUT_W0_OFS 12'h020
`define SLAVE0_OFS 12'h040

`define CTRL_RESET 4'h0
`define CTRL_ALLOC_LSB 0
`define CTRL_FOUR_PT_BIT 2
`define CTRL_LONG_BIT 3

`define NUM_ENTRIES 8
`define NUM_WORDS 4

`define ALLOC_2W 2'h0
`define ALLOC_4W 2'h1

`define KIND_4PT 3'h0
`define KIND_8PT 3'h1
`define KIND_16PT 3'h2
`define KIND_32PT 3'h3
`define KIND_48PT 3'h4
`define KIND_64PT 3'h5

`define CLK_HZ 64'd10000000
`define HS_DELAY_MS 64'd118
`define LD_DELAY_MS 64'd720
`define HS_DELAY_CYC ((`HS_DELAY_MS * `CLK_HZ) / 64'd1000)
`define LD_DELAY_CYC ((`LD_DELAY_MS * `CLK_HZ) / 64'd1000)

`endif

// >>> include/word_alloc_pkg.sv
// Types shared by the slave word allocator.
package word_alloc_pkg;

   typedef enum logic [1:0] {
      ST_SETTLE,
      ST_SCAN,
      ST_RUN
   } phase_e;

   typedef struct packed {
      logic present;
      logic long_mode;
      logic out_dir;
      logic [2:0] kind;
      logic [3:0] setting;
   } entry_s;

   typedef logic [63:0] image_t;

   typedef struct packed {
      phase_e phase;
      logic [22:0] timer;
      logic [1:0] alloc;
      logic four_pt;
      logic long_mode;
      entry_s [7:0] entries;
      image_t in_img;
      image_t out_img;
      logic ack;
      logic pslverr;
      logic [31:0] prdata;
      image_t tx_data;
      logic [7:0] base_word;
      logic [7:0] lamp;
      logic master_lamp;
   } core_s;

endpackage

// >>> core/slot_map.sv
// Placement of one slave in the word image: first bit, bit mask, validity.
`include "word_alloc_defs.svh"

module slot_map (
   // Slave descriptor
   input wire logic [2:0] kind_i,
   input wire logic [3:0] setting_i,
   // Master switches
   input wire logic [1:0] alloc_i,
   input wire logic four_pt_i,
   // Placement
   output logic ok_o,
   output logic [7:0] off_o,
   output logic [63:0] mask_o
);

   logic [6:0] bits;
   logic [4:0] first;
   logic [4:0] nodes;
   logic [5:0] limit;
   logic [5:0] last;

   always_comb begin
      case (kind_i)
         `KIND_4PT: bits = 7'h04;
         `KIND_8PT: bits = 7'h08;
         `KIND_16PT: bits = 7'h10;
         `KIND_32PT: bits = 7'h20;
         `KIND_48PT: bits = 7'h30;
         default: bits = 7'h40;
      endcase
      case (alloc_i)
         `ALLOC_2W: limit = 6'h02;
         `ALLOC_4W: limit = 6'h04;
         default: limit = 6'h08;
      endcase
      if (four_pt_i) begin
         // An 8-point slave simply takes its setting and the next node.
         first = {1'b0, setting_i}; // R21
         nodes = bits[6:2]; // R20
         // Twice the total word count: four nibble nodes per input word.
         limit = {limit[4:0], 1'b0};
         off_o = {1'b0, first, 2'b00}; // R20
      end else begin
         nodes = (bits > 7'h08) ? {1'b0, bits[6:3]} : 5'h01; // R8
         // Multi-node slaves start on the even node of the pair.
         first = (nodes > 5'h01) ? {1'b0, setting_i[3:1], 1'b0}
                                 : {1'b0, setting_i}; // R9 R11 R12 R13 R16
         // The total word count equals the byte nodes of one direction.
         off_o = {first, 3'b000}; // R8 R10
      end
      last = {1'b0, first} + {1'b0, nodes};
      // Slaves of 16 points or more overlap in 4-point mode.
      ok_o = (last <= limit) && !(four_pt_i && bits > 7'h08); // R14 R15
      mask_o = (bits == 7'h40) ? 64'hffffffffffffffff
                              : (64'h1 << bits) - 64'h1; // R10 R17
   end

endmodule // slot_map

// >>> core/slave_io_word_allocator.sv
// Slave input/output word allocator with APB register access.
//
// Behaviour
// [R1] Mode-mismatched slave excluded, lamp dark
// [R2] Communication mode resets to high speed
// [R3] I/O valid after delay plus scan
// [R4] Controller checks alarm before using data
// [R5] Allocation of 2, 4 or 8 words
// [R6] Node width 8 or 4 bits
// [R7] Input and output nodes decoded separately
// [R8] 8-point: two nodes per word, even low
// [R9] 16-point slave pairs nodes in one word
// [R10] 4-point slave: low nibble of its byte
// [R11] 64-point analog spans eight nodes
// [R12] 48-point analog spans six nodes
// [R13] 32-point analog spans four nodes
// [R14] 16-point analog spans two nodes
// [R15] Out-of-range slave excluded, lamp dark
// [R16] 32-point connector takes four nodes
// [R17] 16-point connector as 16-point slave
// [R18] No status area words mapped
// [R19] Base word from mount, bits from node
// [R20] 4-point: four nodes per word, nibbles
// [R21] 4-point: 8-point slave takes two nodes
`include "word_alloc_defs.svh"

module slave_io_word_allocator #(
   parameter logic [22:0] HS_CYC = 23'(`HS_DELAY_CYC),
   parameter logic [22:0] LD_CYC = 23'(`LD_DELAY_CYC)
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Controller side
   input wire logic [3:0] mount_pos_i,
   input wire logic scan_tick_i,
   output logic [7:0] base_word_o,
   output logic io_valid_o,
   output logic alarm_o,
   // Slave link side
   input wire logic rx_valid_i,
   input wire logic [2:0] rx_entry_i,
   input wire logic [63:0] rx_data_i,
   input wire logic [2:0] tx_entry_i,
   output logic [63:0] tx_data_o,
   output logic [7:0] link_ok_lamp_o,
   output logic master_lamp_o
);

   word_alloc_pkg::core_s st;
   word_alloc_pkg::core_s next_st;

   logic [7:0] ok_v;
   logic [7:0] off_v [`NUM_ENTRIES];
   logic [63:0] mask_v [`NUM_ENTRIES];
   logic [7:0] mismatch_v;
   logic [7:0] good_v;
   logic [31:0] rd;
   logic hit;
   logic acc;
   logic wr;
   logic wr_ctrl;
   logic [2:0] words;
   logic [22:0] limit;
   word_alloc_pkg::entry_s rx_ent;
   word_alloc_pkg::entry_s tx_ent;

   for (genvar i = 0; i < `NUM_ENTRIES; i++) begin : g_slot
      slot_map u_map (
         .kind_i(st.entries[i].kind),
         .setting_i(st.entries[i].setting),
         .alloc_i(st.alloc),
         .four_pt_i(st.four_pt),
         .ok_o(ok_v[i]),
         .off_o(off_v[i]),
         .mask_o(mask_v[i])
      );
      assign mismatch_v[i] = st.entries[i].long_mode != st.long_mode;
      // A bad slave is left out; the others keep running.
      assign good_v[i] = st.entries[i].present && !mismatch_v[i]
                         && ok_v[i]; // R1 R15
   end

   assign rx_ent = st.entries[rx_entry_i];
   assign tx_ent = st.entries[tx_entry_i];
   assign limit = st.long_mode ? LD_CYC : HS_CYC; // R3
   assign words = (st.alloc == `ALLOC_2W) ? 3'h1
                : (st.alloc == `ALLOC_4W) ? 3'h2 : 3'h4; // R5

   always_comb begin
      next_st = st;
      next_st.ack = 1'b0;
      next_st.pslverr = 1'b0;
      rd = 32'h0;
      hit = 1'b0;
      acc = psel_i && penable_i && !st.ack;
      // A write lands only at the edge that completes the transfer.
      wr = psel_i && penable_i && pwrite_i && st.ack;
      wr_ctrl = wr && (paddr_i == `CTRL_OFS);

      // Register decode; set-up, status and slave data are visible.
      if (paddr_i == `CTRL_OFS) begin
         hit = 1'b1;
         rd = {28'h0, st.long_mode, st.four_pt, st.alloc};
      end
      if (wr_ctrl) begin
         next_st.alloc = pwdata_i[`CTRL_ALLOC_LSB +: 2]; // R5
         next_st.four_pt = pwdata_i[`CTRL_FOUR_PT_BIT]; // R6
         next_st.long_mode = pwdata_i[`CTRL_LONG_BIT];
      end
      if (paddr_i == `STATUS_OFS) begin
         hit = 1'b1;
         rd = {16'h0, st.lamp, 7'h0, st.phase == word_alloc_pkg::ST_RUN};
      end
      for (int k = 0; k < `NUM_WORDS; k++) begin
         if (paddr_i == `IN_W0_OFS + 12'(4 * k)) begin
            hit = 1'b1;
            rd = {16'h0, st.in_img[16 * k +: 16]};
         end
         if (paddr_i == `OUT_W0_OFS + 12'(4 * k)) begin
            hit = 1'b1;
            rd = {16'h0, st.out_img[16 * k +: 16]};
            if (wr) begin
               next_st.out_img[16 * k +: 16] = pwdata_i[15:0];
            end
         end
      end
      for (int k = 0; k < `NUM_ENTRIES; k++) begin
         if (paddr_i == `SLAVE0_OFS + 12'(4 * k)) begin
            hit = 1'b1;
            rd = {22'h0, st.entries[k]};
            if (wr) begin
               next_st.entries[k] = pwdata_i[9:0];
            end
         end
      end
      // One wait state lets read data come from a flip-flop.
      if (acc) begin
         next_st.ack = 1'b1;
         next_st.prdata = rd;
         next_st.pslverr = !hit; // R18
      end

      // Start-up: settle time set by the mode, then wait for the next controller scan tick.
      case (st.phase)
         word_alloc_pkg::ST_SETTLE: begin
            next_st.timer = st.timer + 23'h1;
            if (st.timer >= limit - 23'h1) begin
               next_st.phase = word_alloc_pkg::ST_SCAN; // R3
            end
         end
         word_alloc_pkg::ST_SCAN: begin
            if (scan_tick_i) begin
               next_st.phase = word_alloc_pkg::ST_RUN; // R3
            end
         end
         word_alloc_pkg::ST_RUN: begin
            next_st.phase = word_alloc_pkg::ST_RUN;
         end
         default: begin
            next_st.phase = word_alloc_pkg::ST_SETTLE;
         end
      endcase

      // Input data lands only in the input image, so an input and an
      // output slave may share one node number.
      if (st.phase == word_alloc_pkg::ST_RUN && rx_valid_i
          && good_v[rx_entry_i] && !rx_ent.out_dir) begin // R7
         next_st.in_img = (st.in_img
            & ~(mask_v[rx_entry_i] << off_v[rx_entry_i]))
            | ((rx_data_i & mask_v[rx_entry_i])
               << off_v[rx_entry_i]); // R8 R9 R19 R20
      end
      if (st.phase == word_alloc_pkg::ST_RUN && good_v[tx_entry_i]
          && tx_ent.out_dir) begin // R7
         next_st.tx_data = (st.out_img >> off_v[tx_entry_i])
                           & mask_v[tx_entry_i]; // R19
      end else begin
         next_st.tx_data = 64'h0; // R15
      end

      next_st.lamp = (st.phase == word_alloc_pkg::ST_RUN) ? good_v
                                                         : 8'h0; // R1
      next_st.master_lamp = st.phase == word_alloc_pkg::ST_RUN; // R1
      next_st.base_word = 8'({4'h0, mount_pos_i} * {5'h0, words}); // R19
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= '0;
         st.phase <= word_alloc_pkg::ST_SETTLE;
         {st.long_mode, st.four_pt, st.alloc} <= `CTRL_RESET; // R2
      end else begin
         st <= next_st;
      end
   end

   assign prdata_o = st.prdata;
   assign pready_o = st.ack;
   assign pslverr_o = st.pslverr;
   assign base_word_o = st.base_word;
   assign io_valid_o = st.phase == word_alloc_pkg::ST_RUN;
   // The controller must see this low before trusting slave data.
   assign alarm_o = !io_valid_o; // R4
   assign tx_data_o = st.tx_data;
   assign link_ok_lamp_o = st.lamp;
   assign master_lamp_o = st.master_lamp;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence s_setup;
      psel_i && !penable_i;
   endsequence

   sequence s_access;
      psel_i && penable_i && !pready_o;
   endsequence

   sequence s_io_up;
      !io_valid_o ##1 io_valid_o;
   endsequence

   AST_APB_ANSWER: assert property ( // R18
      s_setup ##1 s_access |=> pready_o)
      else $error("APB access not answered after one wait state.");

   AST_UNMAPPED_ERR: assert property ( // R18
      acc && !hit |=> pready_o && pslverr_o)
      else $error("Unmapped address did not raise pslverr.");

   AST_MISMATCH_DARK: assert property ( // R1
      ##1 (link_ok_lamp_o & $past(mismatch_v)) == 8'h0)
      else $error("Lamp lit for a slave in the wrong mode.");

   AST_MASTER_LAMP: assert property ( // R1
      io_valid_o |=> master_lamp_o)
      else $error("Master lamp dark while running.");

   AST_DEFAULT_HS: assert property ( // R2
      $rose(st.long_mode) |-> $past(wr_ctrl))
      else $error("Long-distance mode set without a control write.");

   AST_SETTLE_HOLD: assert property ( // R3
      st.phase == word_alloc_pkg::ST_SETTLE && st.timer < limit - 23'h1
      |=> !io_valid_o)
      else $error("I/O valid before the settle time ended.");

   AST_SCAN_GATE: assert property ( // R3
      s_io_up |-> $past(scan_tick_i))
      else $error("I/O valid without a controller scan.");

   AST_ALARM_LOW: assert property ( // R4
      s_io_up |-> !alarm_o ##0 $past(alarm_o))
      else $error("Alarm did not drop when I/O became valid.");

   AST_RANGE_DARK: assert property ( // R15
      ##1 (link_ok_lamp_o & ~$past(ok_v)) == 8'h0)
      else $error("Lamp lit for an out-of-range slave.");

   AST_RX_REJECT: assert property ( // R15
      rx_valid_i && !good_v[rx_entry_i] |=> $stable(st.in_img))
      else $error("Excluded slave changed the input image.");

   AST_OUT_SEPARATE: assert property ( // R7
      rx_valid_i && !wr |=> $stable(st.out_img))
      else $error("Input data changed the output image.");

endmodule // slave_io_word_allocator

// >>> sim/slave_terminal_model.sv
// Behavioural model of the remote slave terminals on the field bus.
module slave_terminal_model (
   // Clock
   input wire logic clk_i,
   // Input slaves towards the master
   output logic rx_valid_o,
   output logic [2:0] rx_entry_o,
   output logic [63:0] rx_data_o,
   // Output slaves served by the master
   output logic [2:0] tx_entry_o,
   input wire logic [63:0] tx_data_i
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      rx_valid_o = 1'b0;
      rx_entry_o = 3'h0;
      rx_data_o = 64'h0;
      tx_entry_o = 3'h0;
   end

   // Data is inverted once the frame ends, so a late sample never passes.
   task automatic send(input logic [2:0] e, input logic [63:0] d);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_entry_o <= e;
      rx_data_o <= d;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o <= ~d;
   endtask

   task automatic fetch(input logic [2:0] e, output logic [63:0] d);
      @(posedge clk_i);
      tx_entry_o <= e;
      @(posedge clk_i);
      @(posedge clk_i);
      d = tx_data_i;
   endtask
endmodule // slave_terminal_model

// >>> sim/test_slave_io_word_allocator.sv
// Self-checking bench for the slave input/output word allocator.
`include "word_alloc_defs.svh"

module test_slave_io_word_allocator;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic [3:0] mount_pos_i = 4'h3;
   logic scan_tick_i = 1'b0;
   logic [7:0] base_word_o;
   logic io_valid_o;
   logic alarm_o;
   logic rx_valid_i;
   logic [2:0] rx_entry_i;
   logic [63:0] rx_data_i;
   logic [2:0] tx_entry_i;
   logic [63:0] tx_data_o;
   logic [7:0] link_ok_lamp_o;
   logic master_lamp_o;
   logic [2:0] tick_cnt = 3'h0;
   int err_count = 0;
   int num_checks = 0;
   int n;
   logic [31:0] rd;
   logic er;
   logic [63:0] tx;
   logic [31:0] cfg [8] = '{32'h211, 32'h202, 32'h225, 32'h236,
                            32'h291, 32'h317, 32'h2c3, 32'h218};
   logic [31:0] exp_in [4] = '{32'ha500, 32'h000f, 32'h1234, 32'h0};

   always #50 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      tick_cnt <= tick_cnt + 3'h1;
      scan_tick_i <= (tick_cnt == 3'h7);
   end

   // Short start-up counts keep the run brief.
   slave_io_word_allocator #(.HS_CYC(23'd20), .LD_CYC(23'd50)) DUT (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .mount_pos_i(mount_pos_i),
      .scan_tick_i(scan_tick_i), .base_word_o(base_word_o),
      .io_valid_o(io_valid_o), .alarm_o(alarm_o), .rx_valid_i(rx_valid_i),
      .rx_entry_i(rx_entry_i), .rx_data_i(rx_data_i),
      .tx_entry_i(tx_entry_i), .tx_data_o(tx_data_o),
      .link_ok_lamp_o(link_ok_lamp_o), .master_lamp_o(master_lamp_o));

   slave_terminal_model slaves (
      .clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_entry_o(rx_entry_i),
      .rx_data_o(rx_data_i), .tx_entry_o(tx_entry_i),
      .tx_data_i(tx_data_o));

   task automatic results();
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge clk_i);
         if (pready_o === 1'b1) break;
      end
      if (k == 16) begin
         err_count++;
         results();
      end
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      chk(alarm_o, 1'b1);
      reset_n_i <= 1'b1;
      apb(1'b0, `CTRL_OFS, 32'h0);
      chk(rd, 32'h0);
      chk(base_word_o, 8'h03);
      chk(io_valid_o, 1'b0);
      for (n = 0; n < 40 && io_valid_o !== 1'b1; n++) @(posedge clk_i);
      if (n == 40) begin
         err_count++;
         results();
      end
      chk(alarm_o, 1'b0);
      apb(1'b1, `CTRL_OFS, 32'h2);
      repeat (2) @(posedge clk_i);
      chk(base_word_o, 8'h0c);
      for (n = 0; n < 8; n++) apb(1'b1, `SLAVE0_OFS + 12'(4 * n), cfg[n]);
      apb(1'b1, `OUT_W0_OFS, 32'h5a00);
      apb(1'b1, `OUT_W0_OFS + 12'h004, 32'hbeef);
      slaves.send(3'h0, 64'ha5);
      slaves.send(3'h1, 64'hff);
      slaves.send(3'h2, 64'h1234);
      slaves.send(3'h3, 64'hffffffff);
      slaves.send(3'h5, 64'hff);
      slaves.send(3'h7, 64'hff);
      for (n = 0; n < 4; n++) begin
         apb(1'b0, `IN_W0_OFS + 12'(4 * n), 32'h0);
         chk(rd, exp_in[n]);
      end
      chk(link_ok_lamp_o, 8'h57);
      chk(master_lamp_o, 1'b1);
      apb(1'b0, `STATUS_OFS, 32'h0);
      chk(rd, 32'h5701);
      slaves.fetch(3'h4, tx);
      chk(tx, 64'h5a);
      slaves.fetch(3'h6, tx);
      chk(tx, 64'hbeef);
      apb(1'b0, 12'h0fc, 32'h0);
      chk(er, 1'b1);
      apb(1'b1, `CTRL_OFS, 32'h6);
      apb(1'b1, `SLAVE0_OFS, 32'h205);
      slaves.send(3'h0, 64'hc);
      apb(1'b0, `IN_W0_OFS + 12'h004, 32'h0);
      chk(rd, 32'h00cf);
      results();
   end
endmodule // test_slave_io_word_allocator
